// ===== pvm_chk.sv
/* Port checker for pvm_monitor: object answers, copies and status.
   Assumes a single mclk domain and rstn active low. */
module pvm_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [31:0] ramp_speed_in,
  input wire logic [31:0] encoder_incr_in,
  input wire logic [31:0] encoder_resolution_in,
  input wire logic [7:0] mode_active_in,
  input wire logic lag_reaction_en,
  input wire logic [15:0] obj_index,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] status_bits,
  input wire logic [31:0] speed_setpoint,
  input wire logic raw_pos_valid,
  input wire logic error_log_entry
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_ack_follows: assert property ((obj_rd || obj_wr) |=> obj_ack)
    else $error("request not answered");
  a_ack_cause: assert property (obj_ack |-> $past(obj_rd || obj_wr))
    else $error("answer without request");
  a_err_with_ack: assert property (obj_err |-> obj_ack)
    else $error("error outside answer");
  a_rdata_idle: assert property (!obj_ack |-> obj_rdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_ro_write: assert property (obj_wr && obj_index == 16'h6064 |=> obj_err)
    else $error("read-only write accepted");
  a_raw_read: assert property ($past(rstn) && obj_rd && !obj_wr && obj_index == 16'h6063
    |=> obj_rdata == $past(encoder_incr_in, 2)) else $error("raw position read wrong");
  a_setpoint_copy: assert property ($past(rstn) |-> speed_setpoint == $past(ramp_speed_in))
    else $error("setpoint not ramp output");
  a_valid_res: assert property ($past(rstn)
    |-> raw_pos_valid == ($past(encoder_resolution_in) != 32'h0000_0000))
    else $error("raw valid flag wrong");
  a_spare_zero: assert property ((status_bits & 16'hDBFF) == 16'h0000)
    else $error("spare status bit set");
  a_log_on_rise: assert property (error_log_entry |-> $rose(status_bits[13]))
    else $error("log entry without lag rise");
  a_log_needed: assert property ($rose(status_bits[13]) && lag_reaction_en
    && $past(lag_reaction_en) |-> error_log_entry) else $error("lag rise not logged");
  a_mode_gate: assert property ((!(mode_active_in inside {8'h01, 8'h07}))[*4]
    |=> !status_bits[10]) else $error("arrival outside position modes");
endmodule // pvm_chk

// ===== pvm_far_side.sv
/* Far side model: trajectory, encoder, ramp generator and mode source.
   Assumes the bench calls its tasks; all levels change at falling edges. */
module pvm_far_side (
  input wire logic mclk,
  output logic [31:0] dem,
  output logic [31:0] act,
  output logic [31:0] tgt,
  output logic [31:0] enc,
  output logic [31:0] ramp,
  output logic [31:0] spd,
  output logic [31:0] res,
  output logic [7:0] mode,
  output logic hom,
  output logic react
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ramp state; only the stepping process writes it
  logic [31:0] ramp_r = 32'h0000_0000;
  // Quiet axis at time zero, reaction configured
  initial
  begin
    {dem, act, tgt, enc} = {4{32'h0000_0000}};
    res = 32'h0000_0400;
    mode = 8'h00;
    hom = 1'b0;
    react = 1'b1;
  end
  // Ramp moves every cycle so a stale copy shows at once
  always @(negedge mclk) ramp_r <= ramp_r + 32'h0000_0003;
  assign ramp = ramp_r;
  assign spd = ramp - 32'h0000_0001;
  task automatic move(input logic [31:0] d, input logic [31:0] a, input logic [31:0] t);
    @(negedge mclk);
    dem = d;
    act = a;
    tgt = t;
  endtask
  task automatic set_mode(input logic [7:0] m);
    @(negedge mclk);
    mode = m;
  endtask
  task automatic set_res(input logic [31:0] r);
    @(negedge mclk);
    res = r;
  endtask
  task automatic set_react(input logic r);
    @(negedge mclk);
    react = r;
  endtask
  // Homing pulse lasts one cycle
  task automatic home(input logic [31:0] e);
    @(negedge mclk);
    enc = e;
    hom = 1'b1;
    @(negedge mclk);
    hom = 1'b0;
  endtask
endmodule // pvm_far_side

// ===== pvm_monitor.sv
/*
  Position and velocity monitor: persistence timer module and the top
  module with its object access port, lag error and arrival checks.
  Assumes position, speed and mode inputs are synchronous to mclk and
  that homing_done is a single-cycle pulse from the homing logic.
*/

// Persistence timer: flag rises once cond has held longer than limit ms
module pvm_dwell (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ms_tick,
  input wire logic enable,
  input wire logic cond,
  input wire logic [15:0] limit,
  output logic flag
);

  // Milliseconds the condition has held so far
  logic [pvm_pkg::DWELL_W-1:0] held_ms;

  // Count ticks while held; saturate so a long hold never wraps
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      held_ms <= '0;
    end
    else if (!enable || !cond)
    begin
      // Any break restarts the wait
      held_ms <= '0;
    end
    else if (ms_tick && (held_ms != {pvm_pkg::DWELL_W{1'b1}}))
    begin
      held_ms <= held_ms + 1'b1;
    end
  end

  // Strictly longer than the limit, so a limit of zero needs one tick
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= enable && cond && (held_ms > {1'b0, limit}); // [R3] [R7]
    end
  end

endmodule // pvm_dwell

module pvm_monitor #(
  parameter int TICK_CYCLES = pvm_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [31:0] demand_pos_in,
  input wire logic [31:0] actual_pos_in,
  input wire logic [31:0] encoder_incr_in,
  input wire logic [31:0] target_pos_in,
  input wire logic [31:0] ramp_speed_in,
  input wire logic [31:0] actual_speed_in,
  input wire logic [7:0] mode_active_in,
  input wire logic homing_done,
  input wire logic [31:0] encoder_resolution_in,
  input wire logic lag_reaction_en,
  input wire logic [15:0] obj_index,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  output logic [15:0] status_bits,
  output logic [31:0] speed_setpoint,
  output logic raw_pos_valid,
  output logic error_log_entry
);

  // Absolute distance between two signed positions, one bit wider
  function automatic logic [32:0] pvm_abs_diff(
    input logic [31:0] a,
    input logic [31:0] b
  );
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? (~d + 33'h0_0000_0001) : d;
  endfunction

  // Writable objects
  logic [31:0] lag_error_band;
  logic [15:0] lag_error_timeout_ms;
  logic [31:0] arrival_band;
  logic [15:0] arrival_dwell_ms;
  // Read-only objects, sampled every clock
  logic [7:0] active_mode_readback;
  logic [31:0] commanded_position;
  logic [31:0] raw_encoder_position;
  logic [31:0] measured_position;
  logic [31:0] ramp_speed_setpoint;
  logic [31:0] measured_speed;
  // Positions captured at homing, subtracted to give user zero
  logic [31:0] demand_home;
  logic [31:0] actual_home;
  // Millisecond time base
  logic [31:0] tick_cnt;
  logic ms_tick;
  // Check conditions and flags
  logic lag_enable;
  logic lag_outside;
  logic lag_flag;
  logic lag_flag_d;
  logic arr_enable;
  logic arr_inside;
  logic arr_flag;
  logic [31:0] next_rdata;
  logic next_err;

  // Divide the clock down to a one-cycle pulse every millisecond
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end
    else if (tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt <= 32'h0000_0000; // [R14]
      ms_tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  // Homing moves the user zero; the raw counter is left alone
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      demand_home <= 32'h0000_0000;
      actual_home <= 32'h0000_0000;
    end
    else if (homing_done)
    begin
      demand_home <= demand_pos_in; // [R10]
      actual_home <= actual_pos_in;
    end
  end

  // Sample live values; homed offsets apply from the cycle after homing
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      active_mode_readback <= pvm_pkg::RST_ACTIVE_MODE; // [R13]
      commanded_position <= 32'h0000_0000;
      raw_encoder_position <= 32'h0000_0000;
      measured_position <= 32'h0000_0000;
      ramp_speed_setpoint <= 32'h0000_0000;
      measured_speed <= 32'h0000_0000;
    end
    else
    begin
      active_mode_readback <= mode_active_in; // [R13]
      commanded_position <= demand_pos_in - demand_home; // [R10]
      measured_position <= actual_pos_in - actual_home; // [R10]
      raw_encoder_position <= encoder_incr_in; // [R10]
      ramp_speed_setpoint <= ramp_speed_in; // [R12]
      measured_speed <= actual_speed_in;
    end
  end

  // Same ramp value goes to the speed controller as is reported
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      speed_setpoint <= 32'h0000_0000;
    end
    else
    begin
      speed_setpoint <= ramp_speed_in; // [R12]
    end
  end
  // Raw position means nothing without a resolution
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      raw_pos_valid <= 1'b0;
    end
    else
    begin
      raw_pos_valid <= (encoder_resolution_in != 32'h0000_0000); // [R11]
    end
  end
  // Lag check compares the homed values; the lag held at homing is subtracted
  assign lag_enable = (lag_error_band != pvm_pkg::BAND_OFF); // [R4]
  assign lag_outside = pvm_abs_diff(measured_position, commanded_position)
    > {1'b0, lag_error_band}; // [R1] [R2]
  // Arrival check only in the two positioning modes
  assign arr_enable = (arrival_band != pvm_pkg::BAND_OFF) // [R9]
    && ((active_mode_readback == pvm_pkg::MODE_PROFILE_POS)
    || (active_mode_readback == pvm_pkg::MODE_INTERP_POS)); // [R8]
  assign arr_inside = pvm_abs_diff(measured_position, target_pos_in)
    < {1'b0, arrival_band}; // [R6]

  // Lag persistence against the timeout object
  pvm_dwell u_lag (
    .mclk(mclk),
    .rstn(rstn),
    .ms_tick(ms_tick),
    .enable(lag_enable),
    .cond(lag_outside),
    .limit(lag_error_timeout_ms),
    .flag(lag_flag)
  );
  // Arrival persistence against the dwell object
  pvm_dwell u_arrive (
    .mclk(mclk),
    .rstn(rstn),
    .ms_tick(ms_tick),
    .enable(arr_enable),
    .cond(arr_inside),
    .limit(arrival_dwell_ms),
    .flag(arr_flag)
  );

  // Status word carries only the two monitor bits; others read zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_bits <= 16'h0000;
    end
    else
    begin
      status_bits <= 16'h0000;
      status_bits[pvm_pkg::STAT_LAG_BIT] <= lag_flag; // [R2]
      status_bits[pvm_pkg::STAT_ARRIVE_BIT] <= arr_flag; // [R6]
    end
  end

  // One log pulse per lag error, only when a reaction is set
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lag_flag_d <= 1'b0;
      error_log_entry <= 1'b0;
    end
    else
    begin
      lag_flag_d <= lag_flag;
      error_log_entry <= lag_flag && !lag_flag_d && lag_reaction_en; // [R5]
    end
  end

  // Writable objects; writes to read-only or unknown indices do nothing
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lag_error_band <= pvm_pkg::RST_LAG_BAND; // [R1]
      lag_error_timeout_ms <= pvm_pkg::RST_LAG_TMO; // [R3]
      arrival_band <= pvm_pkg::RST_ARR_BAND; // [R8]
      arrival_dwell_ms <= pvm_pkg::RST_ARR_DWELL; // [R7]
    end
    else if (obj_wr)
    begin
      // Time objects keep the low half of the written word
      unique case (obj_index)
        pvm_pkg::IDX_LAG_BAND: lag_error_band <= obj_wdata;
        pvm_pkg::IDX_LAG_TMO: lag_error_timeout_ms <= obj_wdata[15:0];
        pvm_pkg::IDX_ARR_BAND: arrival_band <= obj_wdata;
        pvm_pkg::IDX_ARR_DWELL: arrival_dwell_ms <= obj_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux and refusal decode
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    unique case (obj_index)
      // Signed mode byte is sign extended to the word
      pvm_pkg::IDX_ACTIVE_MODE:
        next_rdata = {{24{active_mode_readback[7]}}, active_mode_readback};
      pvm_pkg::IDX_CMD_POS: next_rdata = commanded_position;
      pvm_pkg::IDX_RAW_POS: next_rdata = raw_encoder_position;
      pvm_pkg::IDX_MEAS_POS: next_rdata = measured_position;
      pvm_pkg::IDX_LAG_BAND: next_rdata = lag_error_band;
      pvm_pkg::IDX_LAG_TMO: next_rdata = {16'h0000, lag_error_timeout_ms};
      pvm_pkg::IDX_ARR_BAND: next_rdata = arrival_band;
      pvm_pkg::IDX_ARR_DWELL: next_rdata = {16'h0000, arrival_dwell_ms};
      pvm_pkg::IDX_RAMP_SPEED: next_rdata = ramp_speed_setpoint;
      pvm_pkg::IDX_MEAS_SPEED: next_rdata = measured_speed;
      default: next_err = 1'b1;
    endcase
    // Writes to read-only objects are refused too
    if (obj_wr && (obj_index != pvm_pkg::IDX_LAG_BAND)
        && (obj_index != pvm_pkg::IDX_LAG_TMO)
        && (obj_index != pvm_pkg::IDX_ARR_BAND)
        && (obj_index != pvm_pkg::IDX_ARR_DWELL))
    begin
      next_err = 1'b1;
    end
    // Write data is not echoed
    if (obj_wr || next_err)
    begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Answer one cycle after the request, held for one cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      obj_rdata <= 32'h0000_0000;
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
    end
    else
    begin
      obj_ack <= obj_rd || obj_wr;
      obj_err <= (obj_rd || obj_wr) && next_err;
      obj_rdata <= (obj_rd || obj_wr) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule // pvm_monitor

// ===== pvm_monitor_bench.sv
/* Bench for pvm_monitor: object access, lag and arrival checks, homing.
   Assumes pvm_far_side supplies the levels; short ms tick. */
module pvm_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 10; // Ten clocks per ms keeps waits short
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic obj_wr = 1'b0;
  logic obj_rd = 1'b0;
  logic [15:0] obj_index = 16'h0000;
  logic [31:0] obj_wdata = 32'h0000_0000;
  logic [31:0] obj_rdata, dem, act, enc, tgt, ramp, spd, res, setp;
  logic [15:0] status_bits;
  logic [7:0] mode;
  logic obj_ack, obj_err, hom, react, raw_ok, log_pulse;
  int miscompares = 0;
  int compares = 0;
  int log_count = 0; // Error log pulses seen so far
  // 25 MHz clock
  always #20 mclk = ~mclk;
  // Count log pulses at the edge that samples them
  always @(posedge mclk)
    if (log_pulse === 1'b1)
      log_count++;
  pvm_far_side far (.mclk(mclk), .dem(dem), .act(act), .tgt(tgt), .enc(enc), .ramp(ramp),
    .spd(spd), .res(res), .mode(mode), .hom(hom), .react(react));
  pvm_monitor #(.TICK_CYCLES(TICKS)) dut (.mclk(mclk), .rstn(rstn), .demand_pos_in(dem),
    .actual_pos_in(act), .encoder_incr_in(enc), .target_pos_in(tgt), .ramp_speed_in(ramp),
    .actual_speed_in(spd), .mode_active_in(mode), .homing_done(hom),
    .encoder_resolution_in(res), .lag_reaction_en(react), .obj_index(obj_index),
    .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .status_bits(status_bits),
    .speed_setpoint(setp), .raw_pos_valid(raw_ok), .error_log_entry(log_pulse));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One access; the answer is looked at half a cycle after it is taken, while it stands
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
    input logic [31:0] exp, input logic experr);
    @(negedge mclk);
    obj_wr = wr;
    obj_rd = !wr;
    obj_index = idx;
    obj_wdata = wd;
    @(negedge mclk);
    chk("obj_ack", {31'h0, obj_ack}, 32'h0000_0001);
    chk("obj_err", {31'h0, obj_err}, {31'h0, experr});
    chk("obj_rdata", obj_rdata, exp);
    obj_wr = 1'b0;
    obj_rd = 1'b0;
  endtask
  // Read of a value the far model moves by 3 each cycle; below is how far it reads under the live ramp
  task automatic acc_live(input string what, input logic [15:0] idx, input logic [31:0] below);
    @(negedge mclk);
    obj_rd = 1'b1;
    obj_index = idx;
    @(negedge mclk);
    chk("obj_ack", {31'h0, obj_ack}, 32'h0000_0001);
    chk(what, obj_rdata, ramp - below);
    obj_rd = 1'b0;
  endtask
  // Bounded wait for a status bit; running out ends the run
  task automatic wait_bit(input int b, input logic v, input int bound);
    int n = 0;
    while (status_bits[b] !== v && n < bound)
    begin
      @(negedge mclk);
      n++;
    end
    chk("status_bit", {31'h0, status_bits[b]}, {31'h0, v});
    if (status_bits[b] !== v)
      report_and_stop();
  endtask
  initial
  begin
    logic [15:0] ro [4] = '{16'h6061, 16'h6062, 16'h6063, 16'h6064};
    logic [7:0] modes [3] = '{8'h01, 8'h02, 8'h07};
    cyc(5);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b0, ro[i], 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
      acc(1'b1, ro[i], 32'h0000_0055, 32'h0, 1'b1);
    acc(1'b0, 16'h6065, 32'h0, 32'h0000_0100, 1'b0);
    acc(1'b0, 16'h6066, 32'h0, 32'h0000_0064, 1'b0);
    acc(1'b0, 16'h6067, 32'h0, 32'h0000_000A, 1'b0);
    acc(1'b0, 16'h6068, 32'h0, 32'h0000_0064, 1'b0);
    acc(1'b0, 16'h6069, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 16'h6066, 32'h0001_0002, 32'h0, 1'b0);
    acc(1'b0, 16'h6066, 32'h0, 32'h0000_0002, 1'b0);
    far.set_mode(8'hFF);
    acc(1'b0, 16'h6061, 32'h0, 32'hFFFF_FFFF, 1'b0);
    chk("speed_setpoint", setp, ramp);
    acc_live("ramp_readback", 16'h606B, 32'h0000_0003);
    acc_live("speed_readback", 16'h606C, 32'h0000_0004);
    far.set_mode(8'h00);
    // Lag just past the band, then exactly on it, then the other side
    far.move(32'h0, 32'h0000_0101, 32'h0);
    cyc(20);
    chk("lag_bit", {31'h0, status_bits[13]}, 32'h0);
    wait_bit(13, 1'b1, 30);
    cyc(1);
    chk("log_count", log_count, 32'h0000_0001);
    far.move(32'h0, 32'h0000_0100, 32'h0);
    wait_bit(13, 1'b0, 6);
    far.set_react(1'b0);
    far.move(32'h0000_0101, 32'h0, 32'h0);
    wait_bit(13, 1'b1, 50);
    cyc(1);
    chk("log_count", log_count, 32'h0000_0001);
    acc(1'b1, 16'h6065, 32'hFFFF_FFFF, 32'h0, 1'b0);
    wait_bit(13, 1'b0, 6);
    cyc(60);
    chk("lag_bit", {31'h0, status_bits[13]}, 32'h0);
    // Arrival in position modes only, dwell of one ms
    acc(1'b1, 16'h6068, 32'h0000_0001, 32'h0, 1'b0);
    far.move(32'h0000_1009, 32'h0000_1009, 32'h0000_1000);
    for (int i = 0; i < 3; i++)
    begin
      far.set_mode(modes[i]);
      cyc(10);
      chk("arrive_bit", {31'h0, status_bits[10]}, 32'h0);
      if (i != 1)
        wait_bit(10, 1'b1, 30);
    end
    far.move(32'h0000_100A, 32'h0000_100A, 32'h0000_1000);
    wait_bit(10, 1'b0, 6);
    far.move(32'h0000_0FF7, 32'h0000_0FF7, 32'h0000_1000);
    wait_bit(10, 1'b1, 40);
    acc(1'b1, 16'h6067, 32'hFFFF_FFFF, 32'h0, 1'b0);
    wait_bit(10, 1'b0, 6);
    far.set_res(32'h0);
    cyc(2);
    chk("raw_pos_valid", {31'h0, raw_ok}, 32'h0);
    far.set_res(32'h0000_0400);
    cyc(2);
    chk("raw_pos_valid", {31'h0, raw_ok}, 32'h0000_0001);
    far.home(32'h0000_0070);
    cyc(3);
    acc(1'b0, 16'h6062, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 16'h6064, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 16'h6063, 32'h0, 32'h0000_0070, 1'b0);
    report_and_stop();
  end
endmodule // pvm_monitor_bench
bind pvm_monitor pvm_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk), .rstn(rstn),
  .ramp_speed_in(ramp_speed_in), .encoder_incr_in(encoder_incr_in),
  .encoder_resolution_in(encoder_resolution_in), .mode_active_in(mode_active_in),
  .lag_reaction_en(lag_reaction_en), .obj_index(obj_index), .obj_wr(obj_wr),
  .obj_rd(obj_rd), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
  .status_bits(status_bits), .speed_setpoint(speed_setpoint),
  .raw_pos_valid(raw_pos_valid), .error_log_entry(error_log_entry));

// ===== pvm_pkg.sv
/*
  Constants shared by the position and velocity monitor: object indices,
  reset values, status bit positions, operating mode codes and timing.
  Assumes a 25 MHz system clock and object access by dictionary index.
*/
// How it works
// R1: Lag band symmetric about demand, reset 0x100
// R2: Lag beyond band sets status bit 13
// R3: Lag flag only after timeout ms exceeded
// R4: Band all ones disables lag monitoring
// R5: Lag flag with reaction logs one entry
// R6: Inside arrival band sets status bit 10
// R7: Arrival only after dwell time exceeded
// R8: Arrival check in profile and interpolated position
// R9: Arrival band all ones disables arrival check
// R10: Raw increments survive homing; user positions zeroed
// R11: Zero encoder resolution marks raw position invalid
// R12: Ramp output reported and sent as setpoint
// R13: Active mode readback, signed byte, zero at reset
// R14: Millisecond tick drives both persistence counters
package pvm_pkg;

  // Object dictionary indices
  localparam logic [15:0] IDX_ACTIVE_MODE = 16'h6061;
  localparam logic [15:0] IDX_CMD_POS = 16'h6062;
  localparam logic [15:0] IDX_RAW_POS = 16'h6063;
  localparam logic [15:0] IDX_MEAS_POS = 16'h6064;
  localparam logic [15:0] IDX_LAG_BAND = 16'h6065;
  localparam logic [15:0] IDX_LAG_TMO = 16'h6066;
  localparam logic [15:0] IDX_ARR_BAND = 16'h6067;
  localparam logic [15:0] IDX_ARR_DWELL = 16'h6068;
  localparam logic [15:0] IDX_RAMP_SPEED = 16'h606B;
  localparam logic [15:0] IDX_MEAS_SPEED = 16'h606C;

  // Reset values of the writable objects and the mode readback
  localparam logic [31:0] RST_LAG_BAND = 32'h0000_0100;
  localparam logic [15:0] RST_LAG_TMO = 16'h0064;
  localparam logic [31:0] RST_ARR_BAND = 32'h0000_000A;
  localparam logic [15:0] RST_ARR_DWELL = 16'h0064;
  localparam logic [7:0] RST_ACTIVE_MODE = 8'h00;

  // Band value that switches a check off
  localparam logic [31:0] BAND_OFF = 32'hFFFF_FFFF;

  // Status word bit positions
  localparam int STAT_LAG_BIT = 13;
  localparam int STAT_ARRIVE_BIT = 10;

  // Operating mode codes that use the arrival check
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_INTERP_POS = 8'h07;

  // Timing: one millisecond at a 40 ns clock period
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 40;
  localparam int TICK_CYCLES = MS_NS / CLK_NS;

  // Persistence counter width, one bit wider than the time objects
  localparam int DWELL_W = 17;

endpackage
